// >>> core/ssp_fifo2.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module ssp_fifo2 #(
  parameter int unsigned WIDTH = 8
) (
  // clock, reset and clock enable
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  initial begin
    if (WIDTH < 1) begin
      $error("ssp_fifo2: WIDTH must be at least 1");
    end
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wp;
    logic                  rp;
    logic [1:0]            cnt;
  } ssp_fifo_state_s;

  ssp_fifo_state_s q, d;
  logic            push;
  logic            pop;

  // ready and valid come from the fill count only
  assign in_ready  = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    case ({push, pop})
      2'b10:   d.cnt = q.cnt + 2'h1;
      2'b01:   d.cnt = q.cnt - 2'h1;
      default: d.cnt = q.cnt;
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule : ssp_fifo2

// >>> core/ssp_top.sv
// synchronous serial port: axi4-lite register file, clock divider, shifter
`timescale 1ns/1ns
//
// Operation
// R1 - received eight bits land in low byte of receive register; upper bits reserved
// R2 - two transmit registers hold in low byte the byte to shift out
// R3 - enable outputs follow control bits: bit 1 enable one, bit 0 enable zero
// R4 - both control bits set: only enable zero is high, enable one low
// R5 - serial clock is core clock divided by 2, 4, 8 or 16 per divider field
// R6 - control and status read zero after reset; data registers undefined
// R7 - receive read or transmit write while busy sets error flag, status bit 2
// R8 - error flag clears while both enable control bits are zero
// R9 - completion flag, status bit 1, sets on rising edge completing bit 7
// R10 - completion clears on rx read, tx write, status read, enables off; set wins
// R11 - status bit 0 reads one while a transfer is in progress
// R12 - status register is read-only; writes do not touch its flags
// R13 - tx write while idle shifts byte out msb first, clock toggles only then; code also toggles it after an rx start write
// R14 - peripheral acts only while enabled, changes data away from rising edge
module ssp_top #(
  parameter int unsigned ADDR_W = 8
) (
  // clock, reset and clock enable
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // axi4-lite write address channel
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data channel
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response channel
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read address channel
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // axi4-lite read data channel
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // serial side
  input  wire logic               serial_data_line_in,
  output ssp_pkg::ssp_pins_s      serial_pins
);

  import ssp_pkg::*;

  initial begin
    if (ADDR_W < 7 || ADDR_W > 32) begin
      $error("ssp_top: ADDR_W must lie between 7 and 32");
    end
  end

  typedef struct packed {
    // shifter
    ssp_phase_e  phase;
    logic [3:0]  half_cnt;
    logic [2:0]  bit_cnt;
    logic        receiving;
    logic [7:0]  tx_shift;
    logic [7:0]  rx_shift;
    logic        push;
    // registers
    logic [1:0]  ctl_en;
    logic [1:0]  ctl_div;
    logic [7:0]  tx_zero;
    logic [7:0]  tx_one;
    logic        done;
    logic        err;
    // bus slave
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    // pins
    ssp_pins_s   pins;
  } ssp_state_s;

  ssp_state_s  q, d;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic [7:0]  buf_out_data;
  logic        ar_hs;
  logic [7:0]  ar_addr;

  // half-period reload: divide by 2,4,8,16 gives 1,2,4,8 cycles per half
  function automatic logic [3:0] ssp_half_reload(input logic [1:0] div);
    logic [3:0] half;
    half = 4'h1 << div;
    return half - 4'h1;
  endfunction : ssp_half_reload

  // low address bits only; upper bits must be zero to hit a register
  function automatic logic ssp_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] reg_addr);
    logic [ADDR_W-1:0] full;
    full = '0;
    full[7:0] = reg_addr;
    return addr == full;
  endfunction : ssp_hit

  // enable outputs from control bits, enable zero has priority
  function automatic logic [1:0] ssp_enables(input logic [1:0] en);
    logic [1:0] res;
    res[0] = en[SSP_CTL_EN0_BIT];                            // R3 R4
    res[1] = en[SSP_CTL_EN1_BIT] & ~en[SSP_CTL_EN0_BIT];     // R3 R4
    return res;
  endfunction : ssp_enables

  assign ar_hs         = s_axi_arvalid & q.arready;
  assign ar_addr       = s_axi_araddr[7:0];
  // received bytes drain from the buffer by reads of the receive register
  assign buf_out_ready = ar_hs & ssp_hit(s_axi_araddr, SSP_RECEIVE_ADDR) & buf_out_valid;

  // received bytes wait here so a slow reader loses none
  ssp_fifo2 #(
    .WIDTH (8)
  ) u_rx_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (q.push),
    .in_ready  (buf_in_ready),
    .in_data   (q.rx_shift),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // all next-state logic in one place
  always_comb begin
    logic       busy;
    logic       wr_do;
    logic       wr_lo;
    logic       wr_hi;
    logic       tx_wr;
    logic       start_tx;
    logic       start_rx;
    logic [7:0] start_byte;
    logic       set_done;
    logic       clr_done;
    logic [1:0] en_out;
    busy       = 1'b0;
    wr_do      = 1'b0;
    wr_lo      = 1'b0;
    wr_hi      = 1'b0;
    tx_wr      = 1'b0;
    start_tx   = 1'b0;
    start_rx   = 1'b0;
    start_byte = 8'h00;
    set_done   = 1'b0;
    clr_done   = 1'b0;
    en_out     = 2'h0;
    d          = q;
    busy       = (q.phase != SSP_IDLE);                      // R11

    // capture write address and data in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // perform a write once both halves are held
    if (q.aw_got && q.w_got && !q.bvalid) begin
      wr_do    = 1'b1;
      wr_lo    = q.w_strb[0];
      wr_hi    = q.w_strb[1];
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = SSP_RESP_OKAY;
      case (q.aw_addr)
        SSP_CONTROL_ADDR: begin
          if (wr_lo) begin
            d.ctl_en  = q.w_data[SSP_CTL_EN1_BIT:SSP_CTL_EN0_BIT];
            d.ctl_div = q.w_data[SSP_CTL_DIV_LSB+1:SSP_CTL_DIV_LSB];
          end
        end
        SSP_TX_ZERO_ADDR: begin
          if (wr_lo) begin
            d.tx_zero  = q.w_data[7:0];                      // R2
            tx_wr      = 1'b1;
            start_byte = q.w_data[7:0];
          end
        end
        SSP_TX_ONE_ADDR: begin
          if (wr_lo) begin
            d.tx_one   = q.w_data[7:0];                      // R2
            tx_wr      = 1'b1;
            start_byte = q.w_data[7:0];
          end
        end
        SSP_RX_START_ADDR: begin
          // a receive starts only when idle and the buffer has room; otherwise none starts
          start_rx = (wr_lo | wr_hi) & ~busy & buf_in_ready;
        end
        SSP_STATUS_ADDR: begin
          d.bresp = SSP_RESP_OKAY;                           // R12
        end
        SSP_RECEIVE_ADDR: begin
          d.bresp = SSP_RESP_OKAY;
        end
        default: begin
          d.bresp = SSP_RESP_SLVERR;
        end
      endcase
      if (tx_wr && busy) begin
        d.err = 1'b1;                                        // R7
      end
      start_tx = tx_wr & ~busy;                              // R13
      if (tx_wr) begin
        clr_done = 1'b1;                                     // R10
      end
    end

    // reads answer one cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp  = SSP_RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      case (ar_addr)
        SSP_STATUS_ADDR: begin
          d.rdata[SSP_STS_BUSY_BIT] = busy;                  // R11
          d.rdata[SSP_STS_DONE_BIT] = q.done;
          d.rdata[SSP_STS_ERR_BIT]  = q.err;
          clr_done = 1'b1;                                   // R10
        end
        SSP_CONTROL_ADDR: begin
          d.rdata[SSP_CTL_EN1_BIT:SSP_CTL_EN0_BIT]     = q.ctl_en;
          d.rdata[SSP_CTL_DIV_LSB+1:SSP_CTL_DIV_LSB]   = q.ctl_div;
        end
        SSP_TX_ZERO_ADDR: begin
          d.rdata[7:0] = q.tx_zero;
        end
        SSP_TX_ONE_ADDR: begin
          d.rdata[7:0] = q.tx_one;
        end
        SSP_RECEIVE_ADDR: begin
          d.rdata[7:0] = buf_out_data;                       // R1
          clr_done     = 1'b1;                               // R10
          if (busy) begin
            d.err = 1'b1;                                    // R7
          end
        end
        SSP_RX_START_ADDR: begin
          d.rdata = 32'h0000_0000;
        end
        default: begin
          d.rresp = SSP_RESP_SLVERR;
        end
      endcase
      if (!ssp_hit(s_axi_araddr, ar_addr)) begin
        d.rresp = SSP_RESP_SLVERR;
        d.rdata = 32'h0000_0000;
      end
    end

    // hand the received byte to the buffer and hold until taken
    if (q.push && buf_in_ready) begin
      d.push = 1'b0;
    end

    // shifter: data changes with the falling clock, samples on the rising one
    case (q.phase)
      SSP_IDLE: begin
        d.pins.serial_clock = 1'b0;                          // R13
        if (start_tx || start_rx) begin
          d.phase                      = SSP_LOW;
          d.half_cnt                   = ssp_half_reload(q.ctl_div);  // R5
          d.bit_cnt                    = 3'h0;
          d.receiving                  = start_rx;
          d.tx_shift                   = start_byte;
          d.pins.serial_data_line_out  = start_byte[7];      // R13
          d.pins.serial_data_line_oe_n = start_rx;
        end
      end
      SSP_LOW: begin
        if (q.half_cnt == 4'h0) begin
          d.pins.serial_clock = 1'b1;
          d.rx_shift          = {q.rx_shift[6:0], serial_data_line_in};  // R1 R14
          d.half_cnt          = ssp_half_reload(q.ctl_div);  // R5
          d.phase             = SSP_HIGH;
          if (q.bit_cnt == SSP_LAST_BIT) begin
            set_done = 1'b1;                                 // R9
          end
        end else begin
          d.half_cnt = q.half_cnt - 4'h1;
        end
      end
      SSP_HIGH: begin
        if (q.half_cnt == 4'h0) begin
          d.pins.serial_clock = 1'b0;
          if (q.bit_cnt == SSP_LAST_BIT) begin
            d.phase                      = SSP_IDLE;
            d.pins.serial_data_line_oe_n = 1'b1;
            d.push                       = q.receiving;
          end else begin
            d.phase                     = SSP_LOW;
            d.half_cnt                  = ssp_half_reload(q.ctl_div);
            d.bit_cnt                   = q.bit_cnt + 3'h1;
            d.tx_shift                  = {q.tx_shift[6:0], 1'b0};
            d.pins.serial_data_line_out = q.tx_shift[6];     // R13
          end
        end else begin
          d.half_cnt = q.half_cnt - 4'h1;
        end
      end
      default: begin
        d.phase = SSP_IDLE;
      end
    endcase

    // enables off clears both flags
    if (q.ctl_en == 2'h0) begin
      clr_done = 1'b1;                                       // R10
      d.err    = 1'b0;                                       // R8
    end

    // set wins over clear
    if (set_done) begin
      d.done = 1'b1;                                         // R9 R10
    end else if (clr_done) begin
      d.done = 1'b0;                                         // R10
    end

    // enables and readies registered so every output comes from a flop
    en_out                      = ssp_enables(d.ctl_en);
    d.pins.peripheral_enable_zero = en_out[0];               // R3
    d.pins.peripheral_enable_one  = en_out[1];               // R4
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready  = ~d.w_got & ~d.bvalid;
    d.arready = ~d.rvalid;
  end

  // state register; data registers are cleared too, harmless and deterministic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q                            <= '0;                    // R6
      q.phase                      <= SSP_IDLE;
      q.ctl_en                     <= SSP_CTL_EN_RST;        // R6
      q.ctl_div                    <= SSP_CTL_DIV_RST;
      q.pins.serial_data_line_oe_n <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign serial_pins   = q.pins;

endmodule : ssp_top

// >>> pkg/ssp_pkg.sv
// package: register map, field layout and shared types of the sync serial port
package ssp_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] SSP_STATUS_IDX   = 8'h10;
  localparam logic [7:0] SSP_CONTROL_IDX  = 8'h12;
  localparam logic [7:0] SSP_TX_ZERO_IDX  = 8'h14;
  localparam logic [7:0] SSP_TX_ONE_IDX   = 8'h16;
  localparam logic [7:0] SSP_RECEIVE_IDX  = 8'h18;
  localparam logic [7:0] SSP_RX_START_IDX = 8'h1a;

  localparam logic [7:0] SSP_STATUS_ADDR   = {SSP_STATUS_IDX[5:0], 2'h0};
  localparam logic [7:0] SSP_CONTROL_ADDR  = {SSP_CONTROL_IDX[5:0], 2'h0};
  localparam logic [7:0] SSP_TX_ZERO_ADDR  = {SSP_TX_ZERO_IDX[5:0], 2'h0};
  localparam logic [7:0] SSP_TX_ONE_ADDR   = {SSP_TX_ONE_IDX[5:0], 2'h0};
  localparam logic [7:0] SSP_RECEIVE_ADDR  = {SSP_RECEIVE_IDX[5:0], 2'h0};
  localparam logic [7:0] SSP_RX_START_ADDR = {SSP_RX_START_IDX[5:0], 2'h0};

  // control field positions
  localparam int unsigned SSP_CTL_EN0_BIT = 0;
  localparam int unsigned SSP_CTL_EN1_BIT = 1;
  localparam int unsigned SSP_CTL_DIV_LSB = 4;

  // status field positions
  localparam int unsigned SSP_STS_BUSY_BIT = 0;
  localparam int unsigned SSP_STS_DONE_BIT = 1;
  localparam int unsigned SSP_STS_ERR_BIT  = 2;

  // values after reset
  localparam logic [1:0] SSP_CTL_EN_RST  = 2'h0;
  localparam logic [1:0] SSP_CTL_DIV_RST = 2'h0;

  // bit counter value of the last data bit
  localparam logic [2:0] SSP_LAST_BIT = 3'h7;

  // bus answers
  localparam logic [1:0] SSP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SSP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_LOW,
    SSP_HIGH
  } ssp_phase_e;

  // pins toward the serial peripherals
  typedef struct packed {
    logic serial_clock;
    logic serial_data_line_out;
    logic serial_data_line_oe_n;
    logic peripheral_enable_zero;
    logic peripheral_enable_one;
  } ssp_pins_s;

endpackage : ssp_pkg

// >>> verif/ssp_monitor.sv
// checker: timing and read-back relations at the ports of the serial port
`timescale 1ns/1ns
module ssp_monitor
  import ssp_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic               core_clk,
  input wire logic               rst_n,
  // read channels
  input wire logic [ADDR_W-1:0]  s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // serial pins
  input wire ssp_pkg::ssp_pins_s serial_pins
);
  logic              sclk, oe_n, dout, en0, en1, is_sts, is_rx;
  logic [ADDR_W-1:0] ra_q;
  logic [4:0]        hi_q;

  // short names for the pin fields and the decoded read address
  assign sclk   = serial_pins.serial_clock;
  assign oe_n   = serial_pins.serial_data_line_oe_n;
  assign dout   = serial_pins.serial_data_line_out;
  assign en0    = serial_pins.peripheral_enable_zero;
  assign en1    = serial_pins.peripheral_enable_one;
  assign is_sts = (ra_q == ADDR_W'(SSP_STATUS_ADDR));
  assign is_rx  = (ra_q == ADDR_W'(SSP_RECEIVE_ADDR));

  // read address in flight; high phase length, since the divider is not visible here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ra_q <= '0;
      hi_q <= 5'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
      hi_q <= sclk ? hi_q + 5'h1 : 5'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  en_excl_a: assert property (!(en0 && en1))
    else $error("both peripheral enables high");
  sclk_half_a: assert property ($fell(sclk) |-> hi_q inside {5'h1, 5'h2, 5'h4, 5'h8})
    else $error("serial clock high phase of wrong length");
  tx_hold_a: assert property (!oe_n && !$past(oe_n) && !$fell(sclk) |-> $stable(dout))
    else $error("transmit data moved away from a falling clock");
  rx_rsv_a: assert property (s_axi_rvalid && is_rx |-> s_axi_rdata[31:8] == 24'h0)
    else $error("receive upper bits not zero");
  sts_rsv_a: assert property (s_axi_rvalid && is_sts |-> s_axi_rdata[31:3] == 29'h0)
    else $error("status reserved bits not zero");
  // enables must be off one cycle before the read is taken, else a set flag may still be shown
  err_clr_a: assert property ($rose(s_axi_rvalid) && is_sts && !$past(en0, 2) && !$past(en1, 2) |-> !s_axi_rdata[2])
    else $error("error flag set with enables off");
  busy_rd_a: assert property ($rose(s_axi_rvalid) && is_sts && !$past(oe_n) |-> s_axi_rdata[0])
    else $error("busy flag low during a transfer");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");

  tx_seen_c: cover property ($fell(oe_n));
  slow_clk_c: cover property ($fell(sclk) && hi_q == 5'h8);
  err_rd_c: cover property ($rose(s_axi_rvalid) && is_sts && s_axi_rdata[2]);
endmodule : ssp_monitor

bind ssp_top ssp_monitor #(.ADDR_W(ADDR_W)) u_mon (.core_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_pins);

// >>> verif/ssp_periph_model.sv
// serial peripheral model on the shared data line
`timescale 1ns/1ns
module ssp_periph_model
  import ssp_pkg::*;
(
  // clock and pins
  input  wire logic        core_clk,
  input  ssp_pkg::ssp_pins_s pins,
  // byte sent and byte seen
  input  wire logic [7:0]  send_byte,
  output logic             line,
  output logic [7:0]       seen_byte
);
  logic [3:0] rise_q = 4'h0;
  logic [2:0] idx_q = 3'h0;
  logic       junk_q = 1'b0;
  logic       sel;

  assign sel = pins.peripheral_enable_zero | pins.peripheral_enable_one;

  // sample on the rising serial clock, msb first
  always @(posedge pins.serial_clock) begin
    if (sel) begin
      rise_q <= (rise_q == 4'h8) ? 4'h1 : rise_q + 4'h1;
      seen_byte <= {seen_byte[6:0], pins.serial_data_line_oe_n ? line : pins.serial_data_line_out};
    end
  end

  // next bit on the falling edge, away from the sampling edge
  always @(negedge pins.serial_clock) begin
    if (sel) idx_q <= (rise_q == 4'h8) ? 3'h0 : rise_q[2:0];
  end

  // released line toggles so a stale bit can never look valid
  always @(posedge core_clk) junk_q <= ~line;
  assign line = (sel && pins.serial_data_line_oe_n) ? send_byte[3'h7 - idx_q] : junk_q;
endmodule : ssp_periph_model

// >>> verif/tb.sv
// testbench: register accesses, transmit and receive transfers
`timescale 1ns/1ns
module tb;
  import ssp_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h0;
  logic [7:0]  s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  ssp_pins_s   pins;
  logic        sdl_in, line;
  logic [7:0]  send_byte = 8'h0;
  logic [7:0]  seen_byte, txd, ta;
  logic [7:0]  rxv [4] = '{8'h3c, 8'hc3, 8'h5a, 8'h99};
  int          err_count = 0;
  int          comparisons = 0;
  int          low_n = 0;
  int          low_len = 0;
  int          n;

  ssp_top #(.ADDR_W(8)) dut (.core_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serial_data_line_in(sdl_in), .serial_pins(pins));
  ssp_periph_model u_per (.core_clk, .pins, .send_byte, .line, .seen_byte);

  // wire level: the port drives while its enable is low, else the peripheral
  assign sdl_in = pins.serial_data_line_oe_n ? line : pins.serial_data_line_out;

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // length of each driven stretch of the data line
  always @(posedge core_clk) begin
    if (pins.serial_data_line_oe_n === 1'b0) begin
      low_n <= low_n + 1;
    end else if (low_n != 0) begin
      low_len <= low_n;
      low_n <= 0;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // bus write: both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(what, exp, v);
  endtask : rdc

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("Error watchdog expected done seen hang");
    complete_run();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // reset values, read-only status, unmapped place
    rdc("status", SSP_STATUS_ADDR, 32'h0);
    rdc("control", SSP_CONTROL_ADDR, 32'h0);
    wr(SSP_STATUS_ADDR, 32'hffff_ffff, SSP_RESP_OKAY);
    rdc("status", SSP_STATUS_ADDR, 32'h0);
    wr(8'h7c, 32'h1, SSP_RESP_SLVERR);
    rd(8'h7c, d, r);
    chk("rresp", {30'h0, SSP_RESP_SLVERR}, {30'h0, r});
    $display("test registers done");
    // every enable setting, reserved control bits other than 7:6 written as ones
    for (int c = 0; c < 4; c++) begin
      wr(SSP_CONTROL_ADDR, 32'hffff_ff0c | 32'(c), SSP_RESP_OKAY);
      rdc("control", SSP_CONTROL_ADDR, 32'(c));
      chk("enables", (c == 3) ? 32'h1 : 32'(c), {30'h0, pins.peripheral_enable_one, pins.peripheral_enable_zero});
    end
    $display("test enables done");
    // transmit at every divider, both transmit registers, busy-time accesses
    for (int v = 0; v < 4; v++) begin
      txd = 8'ha5 + 8'(v);
      ta = v[0] ? SSP_TX_ONE_ADDR : SSP_TX_ZERO_ADDR;
      wr(SSP_CONTROL_ADDR, 32'h0, SSP_RESP_OKAY);
      rdc("status", SSP_STATUS_ADDR, 32'h0);
      wr(SSP_CONTROL_ADDR, {26'h0, 2'(v), 4'h1}, SSP_RESP_OKAY);
      wr(ta, {24'h0, txd}, SSP_RESP_OKAY);
      rdc("status", SSP_STATUS_ADDR, 32'h1);
      rd(SSP_RECEIVE_ADDR, d, r);
      wr(ta ^ 8'h08, 32'h0, SSP_RESP_OKAY);
      rdc("status", SSP_STATUS_ADDR, 32'h5);
      n = 0;
      while (pins.serial_data_line_oe_n !== 1'b1 && n < 300) begin
        @(posedge core_clk);
        n++;
      end
      repeat (2) @(posedge core_clk);
      chk("drive_len", 32'(16 << v), 32'(low_len));
      chk("seen", {24'h0, txd}, {24'h0, seen_byte});
      rdc("status", SSP_STATUS_ADDR, 32'h6);
      rdc("status", SSP_STATUS_ADDR, 32'h4);
    end
    $display("test transmit done");
    // receive via enable one; fill the buffer while nothing drains it
    wr(SSP_CONTROL_ADDR, 32'h0, SSP_RESP_OKAY);
    wr(SSP_CONTROL_ADDR, 32'h12, SSP_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      send_byte <= rxv[i];
      wr(SSP_RX_START_ADDR, 32'h1, SSP_RESP_OKAY);
      repeat (40) @(posedge core_clk);
      if (i == 0) begin
        rdc("status", SSP_STATUS_ADDR, 32'h2);
        rdc("receive", SSP_RECEIVE_ADDR, {24'h0, rxv[0]});
      end
    end
    rdc("receive", SSP_RECEIVE_ADDR, {24'h0, rxv[1]});
    rdc("receive", SSP_RECEIVE_ADDR, {24'h0, rxv[2]});
    $display("test receive done");
    complete_run();
  end
endmodule : tb
